// *** core/privilege_protection_checker.sv ***
// Purpose: protection checks, stack switching and fault reporting
// Assumes: execution logic presents one check per cycle and retires instructions
// Notes:   registers on APB, zero wait states
// Function
// - privilege change inside a task switches to the stack kept for target level 0-2.
// - privilege-raising call loads new stack, then pushes old stack segment and pointer.
// - return to the outer level restores that level's stack.
// - gate call copies exactly the gate's parameter word count between stacks.
// - return with stack adjustment restores the caller's stack pointer plus the adjustment.
// - io privilege is flag bits 14:13 and governs I/O instruction checks.
// - iret or popf with level above io privilege keeps the interrupt flag.
// - iret or popf at nonzero level keeps io privilege field, silently.
// - selector past descriptor table limit on segment load gives vector 13.
// - not-present stack segment gives 12, others 11, both restartable.
// - invalid descriptor type loads into segment registers give vector 13.
// - writing code, reading execute-only, writing read-only data give vector 13.
// - offset past limit gives 12 for stack, else 13; offset carry ignored.
// - system instructions at nonzero level give vector 13.
// - I/O, interrupt flag and lock above io privilege give vector 13.
// - error code follows return address, holds selector or zero.
// - return address is the faulting instruction start, except extension overrun.
// - vectors 8 double, 9 overrun, 10 bad task state, 11, 12, 13.
// - error code for 8, 10-13, not 9; 8, 9, 13 not restartable.
// - push-all or pop-all stack wrap faults without restartable state.
// - descriptor privilege 3 usable from level 3, privilege 0 only from level 0; code segment loads skip the privilege check.
// - effective privilege is maximum of selector requested level and current level.
// - second fault in one instruction gives 8; another fault then gives shutdown.
`timescale 1ns/1ps
`default_nettype none
module privilege_protection_checker
	import prot_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire check_req_t  checkReq,
	input  wire logic [15:0] instrStartIp,
	input  wire logic [15:0] currentIp,
	input  wire logic        extFaultValid,
	input  wire logic [7:0]  extFaultVector,
	input  wire logic        instrRetire,
	input  wire logic        nmi,
	input  wire logic        flagWrite,
	input  wire logic        flagFromIretPopf,
	input  wire logic [15:0] flagValue,
	input  wire xfer_req_t   xferReq,
	input  wire logic [15:0] curSs,
	input  wire logic [15:0] curSp,
	input  wire logic        stackOpReady,
	output stack_op_t        stackOp,
	output logic             xferBusy,
	output logic             commitEnable,
	output fault_t           fault,
	output logic [1:0]       currentPrivilegeLevel,
	output logic [15:0]      flagWord
);
	typedef enum {ST_IDLE, ST_LOAD, ST_PUSH_SS, ST_PUSH_SP, ST_COPY, ST_RESTORE} xstate_t;

	logic [31:0] ctrl_q;
	logic [31:0] stackTbl_q [3];
	logic [15:0] flags_q, flags_d;
	logic [1:0]  cpl_q;
	logic [1:0]  faultDepth_q;
	fault_t      fault_q, fault_d;
	xstate_t     state_q, state_d;
	xfer_req_t   xfer_q;
	logic [15:0] oldSs_q, oldSp_q;
	logic [4:0]  copyIdx_q;

	wire         checkOn    = ctrl_q[0];
	wire  [1:0]  io_privilege_level       = flags_q[IO_PRIVILEGE_LEVEL_HI:IO_PRIVILEGE_LEVEL_LO];
	wire  [1:0]  requested_privilege_level        = checkReq.selector[1:0];
	wire  [1:0]  epl        = (requested_privilege_level > cpl_q) ? requested_privilege_level : cpl_q;
	wire         isStack    = (checkReq.seg == SEG_SS);
	wire         isCode     = (checkReq.desc == D_CODE_XO) || (checkReq.desc == D_CODE_RX);
	wire         isData     = (checkReq.desc == D_DATA_RO) || (checkReq.desc == D_DATA_RW);

	// segment register load checks, first match wins
	wire         tblOver    = {checkReq.selector[15:3], 3'b111} > checkReq.tableLimit;
	wire         privBadData = checkReq.descPriv < epl;
	wire         privBadSs  = (checkReq.descPriv != cpl_q) || (requested_privilege_level != cpl_q);
	wire         privBad    = isStack ? privBadSs : privBadData;
	wire         typeBad    = (isStack && (checkReq.desc != D_DATA_RW))
		|| ((checkReq.seg != SEG_CS) && (checkReq.desc == D_SPECIAL))
		|| ((checkReq.seg != SEG_CS) && (checkReq.desc == D_CODE_XO))
		|| ((checkReq.seg == SEG_CS) && isData);
	wire         segLoadBad = tblOver || !checkReq.present || typeBad
		|| (privBad && (checkReq.seg != SEG_CS));

	// operand reference checks; offset is 16 bits so any carry is already dropped
	wire         limitBad   = checkReq.offset > checkReq.segLimit;
	wire         accessBad  = (isCode && checkReq.write)
		|| ((checkReq.desc == D_CODE_XO) && !checkReq.write)
		|| ((checkReq.desc == D_DATA_RO) && checkReq.write);
	wire         operandBad = limitBad || accessBad || checkReq.stackWrap;

	// privileged instruction checks
	wire         sysInstr   = (checkReq.instr >= PI_LIDT) && (checkReq.instr <= PI_HLT);
	wire         ioInstr    = (checkReq.instr >= PI_INS) && (checkReq.instr <= PI_LOCK);
	wire         privInsBad = (sysInstr && (cpl_q != LVL_SYS))
		|| (ioInstr && (cpl_q > io_privilege_level));

	wire         chkSegLoad = checkOn && (checkReq.kind == CK_SEGLOAD);
	wire         chkOperand = checkOn && (checkReq.kind == CK_OPERAND);
	wire         chkPriv    = checkOn && (checkReq.kind == CK_PRIV);
	wire         ownFault   = (chkSegLoad && segLoadBad) || (chkOperand && operandBad)
		|| (chkPriv && privInsBad);
	wire         anyFault   = ownFault || extFaultValid;

	wire  [7:0]  segVec     = tblOver ? VEC_GP
		: !checkReq.present ? (isStack ? VEC_STACK : VEC_NOTPRS)
		: VEC_GP;
	wire  [7:0]  opVec      = (accessBad && !limitBad) ? VEC_GP
		: (isStack ? VEC_STACK : VEC_GP);
	wire  [7:0]  ownVec     = chkSegLoad ? segVec : chkOperand ? opVec : VEC_GP;
	wire  [7:0]  rawVec     = extFaultValid ? extFaultVector : ownVec;
	wire  [15:0] rawErr     = (chkSegLoad && !extFaultValid) ? checkReq.selector : 16'h0000;
	wire         wrapFault  = chkOperand && checkReq.stackWrap && !extFaultValid;

	assign commitEnable = !anyFault && (faultDepth_q == 2'h0);

	// fault classification and double fault escalation
	always_comb begin
		fault_d = fault_q;
		fault_d.valid = 1'b0;
		if (nmi) begin
			fault_d.shutdown = 1'b0;
		end
		if (anyFault && !fault_q.shutdown) begin
			fault_d.valid = 1'b1;
			if (faultDepth_q == 2'h1) begin
				fault_d.vector = VEC_DOUBLE;
				fault_d.errCode = 16'h0000;
			end else begin
				fault_d.vector = rawVec;
				fault_d.errCode = rawErr;
			end
			fault_d.hasErr = (fault_d.vector != VEC_EXTOVR);
			fault_d.restartable = !((fault_d.vector == VEC_DOUBLE)
				|| (fault_d.vector == VEC_EXTOVR) || (fault_d.vector == VEC_GP)
				|| wrapFault);
			fault_d.returnIp = (fault_d.vector == VEC_EXTOVR) ? currentIp : instrStartIp;
			if (faultDepth_q == 2'h2) begin
				fault_d.valid = 1'b0;
				fault_d.shutdown = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fault_q <= '0;
		end else begin
			fault_q <= fault_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || nmi) begin
			faultDepth_q <= 2'h0;
		end else if (anyFault && (faultDepth_q != 2'h3)) begin
			faultDepth_q <= faultDepth_q + 2'h1;
		end else if (instrRetire && !faultDepth_q[1]) begin
			faultDepth_q <= 2'h0;
		end
	end

	// flag word update from iret or popf
	always_comb begin
		flags_d = flags_q;
		if (flagWrite) begin
			flags_d = flagValue;
			if (flagFromIretPopf && (cpl_q > io_privilege_level)) begin
				flags_d[IF_BIT] = flags_q[IF_BIT];
			end
			if (flagFromIretPopf && (cpl_q != LVL_SYS)) begin
				flags_d[IO_PRIVILEGE_LEVEL_HI:IO_PRIVILEGE_LEVEL_LO] = flags_q[IO_PRIVILEGE_LEVEL_HI:IO_PRIVILEGE_LEVEL_LO];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_q <= FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// stack switching sequencer
	wire         xferStart  = xferReq.valid && (state_q == ST_IDLE);
	wire         cplChanges = xferReq.newCpl != cpl_q;
	wire  [1:0]  tgtLvl     = (xfer_q.newCpl > 2'h2) ? 2'h2 : xfer_q.newCpl;
	wire  [31:0] tgtStack   = stackTbl_q[tgtLvl];
	wire  [15:0] restoreSp  = xfer_q.newSp + xfer_q.spAdjust;
	wire         opDone     = stackOp.valid && stackOpReady;
	wire         lastCopy   = (copyIdx_q + 5'h01) >= xfer_q.paramCount;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (xferStart && cplChanges) begin
					state_d = xferReq.isReturn ? ST_RESTORE : ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (opDone) begin
					state_d = ST_PUSH_SS;
				end
			end
			ST_PUSH_SS: begin
				if (opDone) begin
					state_d = ST_PUSH_SP;
				end
			end
			ST_PUSH_SP: begin
				if (opDone) begin
					state_d = (xfer_q.paramCount != 5'h00) ? ST_COPY : ST_IDLE;
				end
			end
			ST_COPY: begin
				if (opDone && lastCopy) begin
					state_d = ST_IDLE;
				end
			end
			ST_RESTORE: begin
				if (opDone) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_comb begin
		stackOp = '0;
		case (state_q)
			ST_LOAD: begin
				stackOp.valid = 1'b1;
				stackOp.kind = SO_LOAD;
				stackOp.ss = tgtStack[31:16];
				stackOp.data = tgtStack[15:0];
			end
			ST_PUSH_SS: begin
				stackOp.valid = 1'b1;
				stackOp.kind = SO_PUSH;
				stackOp.data = oldSs_q;
			end
			ST_PUSH_SP: begin
				stackOp.valid = 1'b1;
				stackOp.kind = SO_PUSH;
				stackOp.data = oldSp_q;
			end
			ST_COPY: begin
				stackOp.valid = 1'b1;
				stackOp.kind = SO_COPY;
				stackOp.ss = oldSs_q;
				stackOp.data = oldSp_q;
				stackOp.index = copyIdx_q;
			end
			ST_RESTORE: begin
				stackOp.valid = 1'b1;
				stackOp.kind = SO_LOAD;
				stackOp.ss = xfer_q.newSs;
				stackOp.data = restoreSp;
			end
			default: begin
				stackOp = '0;
			end
		endcase
	end

	assign xferBusy = state_q != ST_IDLE;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			xfer_q <= '0;
			oldSs_q <= 16'h0000;
			oldSp_q <= 16'h0000;
			copyIdx_q <= 5'h00;
		end else begin
			state_q <= state_d;
			if (xferStart) begin
				xfer_q <= xferReq;
				oldSs_q <= curSs;
				oldSp_q <= curSp;
				copyIdx_q <= 5'h00;
			end else if ((state_q == ST_COPY) && opDone) begin
				copyIdx_q <= copyIdx_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cpl_q <= CPL_RST;
		end else if (xferStart) begin
			cpl_q <= xferReq.newCpl;
		end
	end

	// APB slave, zero wait states
	wire         apbAccess  = psel && penable;
	wire         apbWr      = apbAccess && pwrite;
	wire         selCtrl    = paddr == OFF_CTRL;
	wire         selStatus  = paddr == OFF_STATUS;
	wire         selFault   = paddr == OFF_FAULT;
	wire         selFlags   = paddr == OFF_FLAGS;
	wire         selStk0    = paddr == OFF_STACK0;
	wire         selStk1    = paddr == OFF_STACK1;
	wire         selStk2    = paddr == OFF_STACK2;
	wire  [2:0]  selStk     = {selStk2, selStk1, selStk0};
	wire         mapped     = selCtrl || selStatus || selFault || selFlags || (|selStk);
	wire  [31:0] statusWord = {24'h00_0000, fault_q.shutdown, xferBusy,
		faultDepth_q, io_privilege_level, cpl_q};
	wire  [31:0] faultWord  = {fault_q.restartable, fault_q.hasErr, 6'h00,
		fault_q.vector, fault_q.errCode};
	logic [31:0] readMux;

	always_comb begin
		if (selCtrl) begin
			readMux = ctrl_q;
		end else if (selStatus) begin
			readMux = statusWord;
		end else if (selFault) begin
			readMux = faultWord;
		end else if (selFlags) begin
			readMux = {16'h0000, flags_q};
		end else if (selStk0) begin
			readMux = stackTbl_q[0];
		end else if (selStk1) begin
			readMux = stackTbl_q[1];
		end else if (selStk2) begin
			readMux = stackTbl_q[2];
		end else begin
			readMux = 32'h0000_0000;
		end
	end

	assign pready = 1'b1;
	assign pslverr = apbAccess && !mapped;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			prdata <= 32'h0000_0000;
		end else begin
			if (apbWr && selCtrl) begin
				ctrl_q <= {31'h0000_0000, pwdata[0]};
			end
			if (psel && !penable && !pwrite) begin
				prdata <= readMux;
			end
		end
	end

	for (genvar i = 0; i < 3; i++) begin : g_stack
		always_ff @(posedge clk) begin
			if (rst) begin
				stackTbl_q[i] <= 32'h0000_0000;
			end else if (apbWr && selStk[i]) begin
				stackTbl_q[i] <= pwdata;
			end
		end
	end

	assign fault = fault_q;
	assign currentPrivilegeLevel = cpl_q;
	assign flagWord = flags_q;
endmodule : privilege_protection_checker
`default_nettype wire

// *** inc/prot_pkg.sv ***
// Purpose: shared types and constants of the privilege protection checker
// Assumes: 16-bit selectors, offsets and flag word
// Notes:   register offsets are byte addresses on the APB
package prot_pkg;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_STATUS = 8'h04;
	localparam logic [7:0]  OFF_FAULT  = 8'h08;
	localparam logic [7:0]  OFF_FLAGS  = 8'h0C;
	localparam logic [7:0]  OFF_STACK0 = 8'h10;
	localparam logic [7:0]  OFF_STACK1 = 8'h14;
	localparam logic [7:0]  OFF_STACK2 = 8'h18;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
	localparam logic [15:0] FLAGS_RST  = 16'h0000;
	localparam logic [1:0]  CPL_RST    = 2'h0;
	localparam int          IO_PRIVILEGE_LEVEL_LO    = 13;
	localparam int          IO_PRIVILEGE_LEVEL_HI    = 14;
	localparam int          IF_BIT     = 9;
	localparam logic [7:0]  VEC_DOUBLE = 8'h08;
	localparam logic [7:0]  VEC_EXTOVR = 8'h09;
	localparam logic [7:0]  VEC_BADTSS = 8'h0A;
	localparam logic [7:0]  VEC_NOTPRS = 8'h0B;
	localparam logic [7:0]  VEC_STACK  = 8'h0C;
	localparam logic [7:0]  VEC_GP     = 8'h0D;
	localparam logic [1:0]  LVL_SYS    = 2'h0;

	typedef enum logic [1:0] {SEG_ES, SEG_CS, SEG_SS, SEG_DS} seg_t;
	typedef enum logic [2:0] {D_DATA_RO, D_DATA_RW, D_CODE_XO, D_CODE_RX, D_SPECIAL} desc_t;
	typedef enum logic [1:0] {CK_NONE, CK_SEGLOAD, CK_OPERAND, CK_PRIV} check_t;
	typedef enum logic [3:0] {
		PI_NONE, PI_LIDT, PI_LLDT, PI_LGDT, PI_LTR, PI_LMSW, PI_CTS, PI_HLT,
		PI_INS, PI_IN, PI_OUTS, PI_OUT, PI_STI, PI_CLI, PI_LOCK
	} priv_t;
	typedef enum logic [1:0] {SO_LOAD, SO_PUSH, SO_COPY} stackop_kind_t;

	typedef struct packed {
		check_t      kind;
		seg_t        seg;
		logic [15:0] selector;
		logic [15:0] tableLimit;
		desc_t       desc;
		logic        present;
		logic [1:0]  descPriv;
		logic [15:0] offset;
		logic [15:0] segLimit;
		logic        write;
		logic        stackWrap;
		priv_t       instr;
	} check_req_t;

	typedef struct packed {
		logic        valid;
		logic        isReturn;
		logic [1:0]  newCpl;
		logic [4:0]  paramCount;
		logic [15:0] newSs;
		logic [15:0] newSp;
		logic [15:0] spAdjust;
	} xfer_req_t;

	typedef struct packed {
		logic          valid;
		stackop_kind_t kind;
		logic [15:0]   ss;
		logic [15:0]   data;
		logic [4:0]    index;
	} stack_op_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  vector;
		logic        hasErr;
		logic [15:0] errCode;
		logic        restartable;
		logic [15:0] returnIp;
		logic        shutdown;
	} fault_t;
endpackage : prot_pkg

// *** sim/stack_partner.sv ***
// Purpose: far-side model that accepts stack operations
// Assumes: slow high accepts only every other cycle
// Notes:   accepted operations are logged for the bench
`timescale 1ns/1ps
`default_nettype none
module stack_partner
	import prot_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      slow,
	input  wire stack_op_t stackOp,
	output logic           stackOpReady
);
	stack_op_t opLog[$];
	logic      tog_q;
	assign stackOpReady = !slow || tog_q;
	always @(posedge clk) begin
		tog_q <= !rst && !tog_q;
		if (!rst && stackOp.valid && stackOpReady) opLog.push_back(stackOp);
	end
endmodule : stack_partner
`default_nettype wire

// *** sim/privilege_protection_checker_chk.sv ***
// Purpose: port assertions of the protection checker
// Assumes: check enable stays set
// Notes:   bound to every instance
`timescale 1ns/1ps
`default_nettype none
module privilege_protection_checker_chk
	import prot_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire check_req_t  checkReq,
	input wire logic        extFaultValid,
	input wire logic        flagWrite,
	input wire logic        flagFromIretPopf,
	input wire xfer_req_t   xferReq,
	input wire logic        stackOpReady,
	input wire stack_op_t   stackOp,
	input wire logic        xferBusy,
	input wire logic        commitEnable,
	input wire fault_t      fault,
	input wire logic [1:0]  currentPrivilegeLevel,
	input wire logic [15:0] flagWord
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] retSp_q;
	wire  [1:0]  io_privilege_level = flagWord[IO_PRIVILEGE_LEVEL_HI:IO_PRIVILEGE_LEVEL_LO];
	wire         ifl  = flagWord[IF_BIT];
	wire         cpl0 = currentPrivilegeLevel == LVL_SYS;
	wire         pop  = flagWrite && flagFromIretPopf;
	wire         take = xferReq.valid && !xferBusy && xferReq.newCpl != currentPrivilegeLevel;
	wire         vec  = fault.valid;
	always_ff @(posedge clk) retSp_q <= xferReq.newSp + xferReq.spAdjust;
	sequence s_taken; take; endsequence
	sequence s_load; stackOp.valid && stackOp.kind == SO_LOAD; endsequence
	a_fault_commit: assert property (vec |-> !$past(commitEnable))
		else $error("fault without suppressed commit");
	a_gp_code: assert property (vec && fault.vector == VEC_GP |-> fault.hasErr && !fault.restartable)
		else $error("vector 13 attributes wrong");
	a_ovr_nocode: assert property (vec && fault.vector == VEC_EXTOVR |-> !fault.hasErr)
		else $error("vector 9 carries error code");
	a_notprs_restart: assert property (vec && fault.vector == VEC_NOTPRS |-> fault.hasErr && fault.restartable)
		else $error("vector 11 attributes wrong");
	a_dbl_zero: assert property (vec && fault.vector == VEC_DOUBLE |-> fault.errCode == 16'h0000 && !fault.restartable)
		else $error("double fault code wrong");
	a_sys_lvl0: assert property (checkReq.kind == CK_PRIV && checkReq.instr inside {[PI_LIDT:PI_HLT]}
		&& cpl0 && !extFaultValid |=> !vec)
		else $error("system instruction refused at level 0");
	a_io_refuse: assert property (checkReq.kind == CK_PRIV && checkReq.instr inside {[PI_INS:PI_LOCK]}
		&& currentPrivilegeLevel > io_privilege_level && !fault.shutdown |=> vec || fault.shutdown)
		else $error("io instruction not refused");
	a_io_privilege_level_kept: assert property (pop && !cpl0 |=> io_privilege_level == $past(io_privilege_level))
		else $error("io privilege changed");
	a_if_kept: assert property (pop && currentPrivilegeLevel > io_privilege_level |=> ifl == $past(ifl))
		else $error("interrupt flag changed");
	a_xfer_load: assert property (s_taken |=> s_load)
		else $error("no stack load after level change");
	a_op_hold: assert property (stackOp.valid && !stackOpReady |=> stackOp.valid && $stable(stackOp))
		else $error("stack operation dropped");
	a_ret_adjust: assert property (s_taken ##0 xferReq.isReturn |=> s_load ##0 stackOp.data == retSp_q)
		else $error("return stack pointer wrong");
endmodule : privilege_protection_checker_chk
bind privilege_protection_checker privilege_protection_checker_chk chk (.clk, .rst, .checkReq,
	.extFaultValid, .flagWrite, .flagFromIretPopf, .xferReq, .stackOpReady, .stackOp, .xferBusy,
	.commitEnable, .fault, .currentPrivilegeLevel, .flagWord);
`default_nettype wire

// *** sim/privilege_protection_checker_tb.sv ***
// Purpose: self-checking bench of the protection checker
// Assumes: zero-wait register bus
// Notes:   old stack is fixed at 0023:0F00
`timescale 1ns/1ps
`default_nettype none
module privilege_protection_checker_tb;
	import prot_pkg::*;
	logic        clk = '0, rst = '1, psel = '0, penable = '0, pwrite = '0, slow = '0;
	logic        extFaultValid = '0, instrRetire = '0, nmi = '0, flagWrite = '0;
	logic        flagFromIretPopf = '0, pready, pslverr, stackOpReady, xferBusy, commitEnable;
	logic        lastErr;
	logic [1:0]  currentPrivilegeLevel;
	logic [7:0]  paddr = '0, extFaultVector = '0;
	logic [15:0] instrStartIp = '0, currentIp = '0, flagValue = '0, flagWord;
	logic [15:0] curSs = 16'h0023, curSp = 16'h0F00, ip = 16'h0100;
	logic [31:0] pwdata = '0, prdata, rd;
	int          failCount, testsRun;
	check_req_t  checkReq = '0;
	xfer_req_t   xferReq = '0;
	stack_op_t   stackOp;
	fault_t      fault;
	privilege_protection_checker DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .checkReq, .instrStartIp, .currentIp, .extFaultValid,
		.extFaultVector, .instrRetire, .nmi, .flagWrite, .flagFromIretPopf, .flagValue, .xferReq,
		.curSs, .curSp, .stackOpReady, .stackOp, .xferBusy, .commitEnable, .fault,
		.currentPrivilegeLevel, .flagWord);
	stack_partner partner (.clk, .rst, .slow, .stackOp, .stackOpReady);
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	task automatic tmo;
		failCount++;
		report_and_stop;
	endtask : tmo
	task automatic cmp(input string n, input logic [47:0] e, input logic [47:0] s);
		testsRun++;
		if (s !== e) begin
			failCount++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= '1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= '1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) tmo;
		rd = prdata;
		lastErr = pslverr;
		psel <= '0;
		penable <= '0;
	endtask : apb
	function automatic check_req_t mk(check_t k, seg_t s, desc_t d, logic p, w, logic [15:0] o);
		return '{k, s, 16'h0010, 16'hFFFF, d, p, 2'h0, o, 16'h0100, w, 1'b0, PI_NONE};
	endfunction : mk
	task automatic chk(input check_req_t r, input logic [7:0] xv, v, input logic [15:0] e,
		input logic he, rs, ret);
		@(posedge clk);
		checkReq <= r;
		extFaultValid <= xv != 8'h00;
		extFaultVector <= xv;
		instrStartIp <= ip;
		currentIp <= ip + 16'h0003;
		@(negedge clk);
		cmp("commit", v == 8'h00 && ret, commitEnable);
		@(posedge clk);
		checkReq <= '0;
		extFaultValid <= '0;
		instrRetire <= ret;
		@(negedge clk);
		cmp("valid", v != 8'h00, fault.valid);
		if (v != 8'h00) cmp("fault", {v, e, he, rs, v == VEC_EXTOVR ? ip + 16'h0003 : ip},
			{fault.vector, fault.errCode, fault.hasErr, fault.restartable, fault.returnIp});
		ip = ip + 16'h0010;
		@(posedge clk);
		instrRetire <= '0;
	endtask : chk
	task automatic xfer(input logic ret, input logic [1:0] c, input logic [4:0] n,
		input logic [15:0] ss, sp, adj);
		partner.opLog.delete();
		@(posedge clk);
		xferReq <= '{1'b1, ret, c, n, ss, sp, adj};
		@(posedge clk);
		xferReq <= '0;
		for (int i = 0; i < 64; i++) begin
			@(negedge clk);
			if (xferBusy === 1'b0) break;
		end
		if (xferBusy !== 1'b0) tmo;
		cmp("cpl", c, currentPrivilegeLevel);
	endtask : xfer
	task automatic ops(input logic [15:0] ss, sp, input int n);
		stack_op_t lg[$];
		lg = partner.opLog;
		cmp("nops", 3 + n, lg.size());
		cmp("load", {SO_LOAD, ss, sp}, {lg[0].kind, lg[0].ss, lg[0].data});
		cmp("push", {SO_PUSH, curSs, SO_PUSH, curSp}, {lg[1].kind, lg[1].data, lg[2].kind, lg[2].data});
		for (int i = 0; i < n; i++) begin
			cmp("copy", {SO_COPY, curSp, 5'(i)}, {lg[3+i].kind, lg[3+i].data, lg[3+i].index});
		end
	endtask : ops
	task automatic fw(input logic [15:0] val, exp);
		@(posedge clk);
		flagWrite <= '1;
		flagFromIretPopf <= '1;
		flagValue <= val;
		@(posedge clk);
		flagWrite <= '0;
		@(negedge clk);
		cmp("flags", exp, flagWord);
	endtask : fw
	task automatic t_regs;
		apb('0, OFF_CTRL, '0);
		cmp("ctrl", CTRL_RST, rd);
		apb('1, OFF_CTRL, '0);
		chk(mk(CK_SEGLOAD, SEG_DS, D_SPECIAL, '1, '0, '0), '0, '0, '0, '0, '0, '1);
		apb('1, OFF_CTRL, 32'h0000_0001);
		apb('0, OFF_CTRL, '0);
		cmp("ctrlback", CTRL_RST, rd);
		apb('1, OFF_FLAGS, 32'hFFFF_FFFF);
		apb('0, OFF_FLAGS, '0);
		cmp("flagsro", FLAGS_RST, rd);
		apb('0, 8'h40, '0);
		cmp("unmapped", {1'b1, 32'h0000_0000}, {lastErr, rd});
		apb('1, OFF_STACK1, 32'h0033_0E00);
		apb('1, OFF_STACK2, 32'h0043_0D00);
		apb('0, OFF_STACK1, '0);
		cmp("stack1", 32'h0033_0E00, rd);
	endtask : t_regs
	task automatic t_seg;
		seg_t       sg[7] = '{SEG_SS, SEG_SS, SEG_SS, SEG_SS, SEG_DS, SEG_ES, SEG_CS};
		desc_t      dt[7] = '{D_DATA_RO, D_SPECIAL, D_CODE_XO, D_CODE_RX, D_SPECIAL, D_CODE_XO, D_DATA_RW};
		check_req_t r;
		for (int i = 0; i < 7; i++) begin
			chk(mk(CK_SEGLOAD, sg[i], dt[i], '1, '0, '0), '0, VEC_GP, 16'h0010, '1, '0, '1);
		end
		chk(mk(CK_SEGLOAD, SEG_SS, D_DATA_RW, '1, '0, '0), '0, '0, '0, '0, '0, '1);
		chk(mk(CK_SEGLOAD, SEG_SS, D_DATA_RW, '0, '0, '0), '0, VEC_STACK, 16'h0010, '1, '1, '1);
		chk(mk(CK_SEGLOAD, SEG_DS, D_DATA_RW, '0, '0, '0), '0, VEC_NOTPRS, 16'h0010, '1, '1, '1);
		chk(mk(CK_OPERAND, SEG_CS, D_CODE_RX, '1, '1, '0), '0, VEC_GP, '0, '1, '0, '1);
		chk(mk(CK_OPERAND, SEG_CS, D_CODE_XO, '1, '0, '0), '0, VEC_GP, '0, '1, '0, '1);
		chk(mk(CK_OPERAND, SEG_DS, D_DATA_RO, '1, '1, '0), '0, VEC_GP, '0, '1, '0, '1);
		chk(mk(CK_OPERAND, SEG_DS, D_DATA_RO, '1, '0, 16'h0100), '0, '0, '0, '0, '0, '1);
		chk(mk(CK_OPERAND, SEG_SS, D_DATA_RW, '1, '1, 16'h0101), '0, VEC_STACK, '0, '1, '1, '1);
		chk(mk(CK_OPERAND, SEG_DS, D_DATA_RW, '1, '0, 16'h0101), '0, VEC_GP, '0, '1, '0, '1);
		r = mk(CK_OPERAND, SEG_SS, D_DATA_RW, '1, '1, '0);
		r.stackWrap = '1;
		chk(r, '0, VEC_STACK, '0, '1, '0, '1);
		r = mk(CK_SEGLOAD, SEG_DS, D_DATA_RW, '1, '0, '0);
		r.selector = 16'h0100;
		r.tableLimit = 16'h0007;
		chk(r, '0, VEC_GP, 16'h0100, '1, '0, '1);
		r.selector = 16'h0013;
		r.tableLimit = 16'hFFFF;
		r.descPriv = 2'h2;
		chk(r, '0, VEC_GP, 16'h0013, '1, '0, '1);
		r.descPriv = 2'h3;
		chk(r, '0, '0, '0, '0, '0, '1);
		r = mk(CK_PRIV, SEG_DS, D_DATA_RW, '1, '0, '0);
		r.instr = PI_HLT;
		chk(r, '0, '0, '0, '0, '0, '1);
	endtask : t_seg
	task automatic t_xfer;
		check_req_t r;
		slow <= '1;
		xfer('0, 2'h1, 5'd2, '0, '0, '0);
		ops(16'h0033, 16'h0E00, 2);
		slow <= '0;
		r = mk(CK_PRIV, SEG_DS, D_DATA_RW, '1, '0, '0);
		for (int i = PI_LIDT; i <= PI_LOCK; i++) begin
			r.instr = priv_t'(i);
			chk(r, '0, VEC_GP, '0, '1, '0, '1);
		end
		chk(mk(CK_SEGLOAD, SEG_DS, D_DATA_RW, '1, '0, '0), '0, VEC_GP, 16'h0010, '1, '0, '1);
		fw(16'h6200, 16'h0000);
		xfer('1, 2'h0, '0, 16'h0023, 16'h1000, 16'h0004);
		cmp("retn", 1, partner.opLog.size());
		cmp("retop", {SO_LOAD, 16'h0023, 16'h1004}, {partner.opLog[0].kind, partner.opLog[0].ss,
			partner.opLog[0].data});
		fw(16'h6200, 16'h6200);
		xfer('0, 2'h3, '0, '0, '0, '0);
		ops(16'h0043, 16'h0D00, 0);
		r.instr = PI_STI;
		chk(r, '0, '0, '0, '0, '0, '1);
		r.instr = PI_HLT;
		chk(r, '0, VEC_GP, '0, '1, '0, '1);
		fw(16'h0000, 16'h6000);
		xfer('1, 2'h0, '0, 16'h0023, 16'h0F00, '0);
		apb('0, OFF_STATUS, '0);
		cmp("status", 4'hC, rd[3:0]);
	endtask : t_xfer
	task automatic t_double;
		check_req_t r;
		r = mk(CK_OPERAND, SEG_DS, D_DATA_RO, '1, '1, '0);
		chk(r, '0, VEC_GP, '0, '1, '0, '0);
		chk(r, '0, VEC_DOUBLE, '0, '1, '0, '0);
		chk(r, '0, '0, '0, '0, '0, '0);
		cmp("shutdown", 1'b1, fault.shutdown);
		@(posedge clk);
		instrRetire <= '1;
		@(posedge clk);
		instrRetire <= '0;
		@(negedge clk);
		cmp("held", 1'b1, fault.shutdown);
		cmp("shutcommit", 1'b0, commitEnable);
		@(posedge clk);
		nmi <= '1;
		@(posedge clk);
		nmi <= '0;
		@(negedge clk);
		cmp("left", 1'b0, fault.shutdown);
		chk('0, VEC_EXTOVR, VEC_EXTOVR, '0, '0, '0, '1);
		chk('0, VEC_BADTSS, VEC_BADTSS, '0, '1, '1, '1);
	endtask : t_double
	initial begin
		repeat (20000) @(posedge clk);
		tmo;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= '0;
		t_regs;
		t_seg;
		t_xfer;
		t_double;
		report_and_stop;
	end
endmodule : privilege_protection_checker_tb
`default_nettype wire
